// ### hdl/dbcs_pkg.sv
package dbcs_pkg;

  // geometry
  localparam int unsigned NUM_SUB   = 4;   // sub-channels 0A, 0B, 1A, 1B
  localparam int unsigned NUM_CHAN  = 2;   // full address channels 0, 1
  localparam int unsigned DATA_W    = 16;  // byte or word unit
  localparam int unsigned BUF_DEPTH = 2;   // entries in the data buffer

  // transfer mode of a full address channel
  localparam logic [1:0] MODE_STEAL = 2'h0;
  localparam logic [1:0] MODE_BURST = 2'h1;
  localparam logic [1:0] MODE_BLOCK = 2'h2;

  // values after reset
  localparam logic [3:0] PEND_RST = 4'h0;
  localparam logic [1:0] MRUN_RST = 2'h0;
  localparam logic [1:0] CHAN_RST = 2'h0;
  localparam logic [3:0] ENDLY_RST = 4'h0;

  // bus-cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_DEAD,
    ST_RELEASE,
    ST_HOLD
  } dbcs_state_t;

endpackage : dbcs_pkg

// ### hdl/dbcs_stream_if.sv
`timescale 1ns/10ps
// one-way word stream with valid/ready handshake
interface dbcs_stream_if #(
  parameter int unsigned W = 16
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : dbcs_stream_if

// ### hdl/dbcs_pair_buf.sv
`timescale 1ns/10ps
// two-entry buffer between the read phase and the write phase
module dbcs_pair_buf (
  // clock and reset
  input wire logic    clk,
  input wire logic    rst_n,
  // filling side
  dbcs_stream_if.snk  fillPort,
  // draining side
  dbcs_stream_if.src  drainPort
);

  logic [dbcs_pkg::DATA_W-1:0] mem_r [dbcs_pkg::BUF_DEPTH];
  logic [dbcs_pkg::DATA_W-1:0] mem_nxt [dbcs_pkg::BUF_DEPTH];
  logic                        wrPtr_r, wrPtr_nxt;
  logic                        rdPtr_r, rdPtr_nxt;
  logic [1:0]                  count_r, count_nxt;
  logic                        push, pop;

  // full and empty come straight from the occupancy count
  assign fillPort.ready  = (count_r != 2'h2);
  assign drainPort.valid = (count_r != 2'h0);
  assign drainPort.data  = mem_r[rdPtr_r];
  assign push            = fillPort.valid & fillPort.ready;
  assign pop             = drainPort.valid & drainPort.ready;

  // pointer and storage update
  always_comb begin
    mem_nxt   = mem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (push) begin
      mem_nxt[wrPtr_r] = fillPort.data;
      wrPtr_nxt        = ~wrPtr_r;
    end
    if (pop) begin
      rdPtr_nxt = ~rdPtr_r;
    end
    if (push && !pop) begin
      count_nxt = count_r + 2'h1;
    end else if (pop && !push) begin
      count_nxt = count_r - 2'h1;
    end
  end

  // register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
      for (int i = 0; i < dbcs_pkg::BUF_DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
      mem_r   <= mem_nxt;
    end
  end

endmodule : dbcs_pair_buf

// ### hdl/dbcs_sequencer.sv
`timescale 1ns/10ps
module dbcs_sequencer (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // channel control, sub-channel order 0A 0B 1A 1B
  input  wire logic [3:0]                  channelRunFlag,
  input  wire logic [1:0]                  masterRunSet,
  input  wire logic [1:0]                  masterRunClr,
  input  wire logic [1:0]                  fullAddrMode,
  input  wire logic [3:0]                  xferMode,
  input  wire logic [3:0]                  levelReqSel,
  input  wire logic [3:0]                  transferRequestLine_n,
  input  wire logic                        nmi,
  // transfer counter status for the unit in progress
  input  wire logic [3:0]                  lastUnit,
  input  wire logic [3:0]                  blockEnd,
  input  wire logic [3:0]                  srcInternal,
  input  wire logic [3:0]                  dstInternal,
  // bus controller
  output logic                             busReq,
  input  wire logic                        busGrant,
  output logic                             cycReq,
  output logic                             cycWrite,
  output logic [1:0]                       cycChan,
  output logic                             extAddrEn,
  input  wire logic                        cycAck,
  input  wire logic [dbcs_pkg::DATA_W-1:0] rdData,
  output logic [dbcs_pkg::DATA_W-1:0]      wrData,
  input  wire logic                        cpuCycleDone,
  // external bus release
  input  wire logic                        extBusReq,
  input  wire logic                        writeBufBusy,
  output logic                             extReleaseOk,
  // status
  output logic [1:0]                       masterRunFlag,
  output logic [3:0]                       reqPending,
  output logic                             unitDone,
  output logic [1:0]                       unitChan,
  output logic                             xferDone
);

  dbcs_pkg::dbcs_state_t state_r, state_nxt;
  logic [1:0]            chan_r, chan_nxt;
  logic [1:0]            mrun_r, mrun_nxt;
  logic [3:0]            pend_r, pend_nxt;
  logic [3:0]            enDly_r;
  logic                  unitDone_r, unitDone_nxt;
  logic [1:0]            unitChan_r, unitChan_nxt;
  logic                  xferDone_r, xferDone_nxt;
  logic [3:0]            chanEn;
  logic [1:0]            chMode [4];
  logic [1:0]            effMode;
  logic [3:0]            blocked;
  logic [1:0]            winner;
  logic                  anyPend;
  logic                  activate;
  logic                  inPair;
  logic                  internalOnly;

  dbcs_stream_if #(.W(dbcs_pkg::DATA_W)) fillIf ();
  dbcs_stream_if #(.W(dbcs_pkg::DATA_W)) drainIf ();

  // read data parks here until the write phase takes it
  dbcs_pair_buf u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .fillPort  (fillIf.snk),
    .drainPort (drainIf.src)
  );

  // per sub-channel enable and effective mode
  always_comb begin
    for (int i = 0; i < dbcs_pkg::NUM_SUB; i++) begin
      if (fullAddrMode[i/2]) begin
        // B half is folded into its A half in full mode
        chanEn[i] = (i % 2 == 0) ? (channelRunFlag[i] & mrun_r[i/2]) : 1'b0;
        chMode[i] = xferMode[(i/2)*2 +: 2];
      end else begin
        chanEn[i] = channelRunFlag[i];
        chMode[i] = dbcs_pkg::MODE_STEAL;
      end
    end
  end

  // a level request outside block mode gives up the bus after every unit
  assign effMode = (levelReqSel[chan_r] && chMode[chan_r] != dbcs_pkg::MODE_BLOCK) ?
                   dbcs_pkg::MODE_STEAL : chMode[chan_r];

  assign inPair = (state_r == dbcs_pkg::ST_READ) || (state_r == dbcs_pkg::ST_WRITE);

  // the owning channel stops sampling until write end or hold end, or dead-cycle end in block mode
  always_comb begin
    for (int i = 0; i < dbcs_pkg::NUM_SUB; i++) begin
      blocked[i] = (chan_r == 2'(i)) &&
                   (inPair || state_r == dbcs_pkg::ST_HOLD ||
                    (state_r == dbcs_pkg::ST_DEAD && effMode == dbcs_pkg::MODE_BLOCK));
    end
  end

  // fixed priority pick: lowest index wins
  always_comb begin
    winner  = 2'h0;
    anyPend = 1'b0;
    for (int i = dbcs_pkg::NUM_SUB - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        winner  = 2'(i);
        anyPend = 1'b1;
      end
    end
  end

  // a grant is only taken in the idle state, reached after every release to the CPU; a hold goes back to the read without it
  assign activate = (state_r == dbcs_pkg::ST_IDLE) && anyPend && busGrant;

  // request sampling and pending latch
  always_comb begin
    pend_nxt = pend_r;
    for (int i = 0; i < dbcs_pkg::NUM_SUB; i++) begin
      if (!chanEn[i]) begin
        pend_nxt[i] = 1'b0;
      end else if (activate && winner == 2'(i)) begin
        // the activation consumes the request, so it wins over a same-cycle sample
        pend_nxt[i] = 1'b0;
      end else if (enDly_r[i] && !blocked[i]) begin
        // sampling starts the edge after the enabling write took effect
        if (!levelReqSel[i] || !transferRequestLine_n[i]) begin
          pend_nxt[i] = 1'b1;
        end
      end
    end
  end

  // master run flags: software set and clear, NMI clears burst channels
  always_comb begin
    mrun_nxt = mrun_r;
    for (int c = 0; c < dbcs_pkg::NUM_CHAN; c++) begin
      if (masterRunSet[c]) begin
        mrun_nxt[c] = 1'b1;
      end
      if (masterRunClr[c]) begin
        mrun_nxt[c] = 1'b0;
      end
      // block, cycle steal and short mode never see the NMI
      if (nmi && fullAddrMode[c] && xferMode[c*2 +: 2] == dbcs_pkg::MODE_BURST) begin
        mrun_nxt[c] = 1'b0;
      end
    end
  end

  // bus-cycle sequencer
  always_comb begin
    state_nxt    = state_r;
    chan_nxt     = chan_r;
    unitDone_nxt = 1'b0;
    unitChan_nxt = unitChan_r;
    xferDone_nxt = 1'b0;
    case (state_r)
      dbcs_pkg::ST_IDLE: begin
        if (activate) begin
          chan_nxt  = winner;
          state_nxt = dbcs_pkg::ST_READ;
        end
      end
      dbcs_pkg::ST_READ: begin
        // no release path out of the read: the write must follow
        if (cycAck) begin
          state_nxt = dbcs_pkg::ST_WRITE;
        end
      end
      dbcs_pkg::ST_WRITE: begin
        if (cycAck) begin
          unitDone_nxt = 1'b1;
          unitChan_nxt = chan_r;
          if (lastUnit[chan_r]) begin
            // a final unit runs out even after its enable was dropped
            xferDone_nxt = 1'b1;
            state_nxt    = dbcs_pkg::ST_DEAD;
          end else if (effMode == dbcs_pkg::MODE_BLOCK) begin
            if (blockEnd[chan_r]) begin
              state_nxt = dbcs_pkg::ST_DEAD;
            end else if (extBusReq) begin
              state_nxt = dbcs_pkg::ST_HOLD;
            end else begin
              state_nxt = dbcs_pkg::ST_READ;
            end
          end else if (effMode == dbcs_pkg::MODE_BURST) begin
            // an NMI or clear landing with the write ack still keeps the next unit from starting
            if (!chanEn[chan_r] || !mrun_nxt[chan_r[1]]) begin
              state_nxt = dbcs_pkg::ST_RELEASE;
            end else if (extBusReq) begin
              state_nxt = dbcs_pkg::ST_HOLD;
            end else begin
              state_nxt = dbcs_pkg::ST_READ;
            end
          end else begin
            state_nxt = dbcs_pkg::ST_RELEASE;
          end
        end
      end
      dbcs_pkg::ST_DEAD: begin
        state_nxt = dbcs_pkg::ST_RELEASE;
      end
      dbcs_pkg::ST_RELEASE: begin
        // bus stays with the CPU until it has run one cycle
        if (cpuCycleDone) begin
          state_nxt = dbcs_pkg::ST_IDLE;
        end
      end
      dbcs_pkg::ST_HOLD: begin
        // same channel resumes, higher requests keep waiting; a burst that
        // was stopped while the bus was away gives it back instead
        if (!extBusReq) begin
          if (effMode == dbcs_pkg::MODE_BURST && !chanEn[chan_r]) begin
            state_nxt = dbcs_pkg::ST_RELEASE;
          end else begin
            state_nxt = dbcs_pkg::ST_READ;
          end
        end
      end
      default: begin
        state_nxt = dbcs_pkg::ST_IDLE;
      end
    endcase
  end

  // registers of the sequencer, pending latch and run flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= dbcs_pkg::ST_IDLE;
      chan_r     <= dbcs_pkg::CHAN_RST;
      mrun_r     <= dbcs_pkg::MRUN_RST;
      pend_r     <= dbcs_pkg::PEND_RST;
      enDly_r    <= dbcs_pkg::ENDLY_RST;
      unitDone_r <= 1'b0;
      unitChan_r <= dbcs_pkg::CHAN_RST;
      xferDone_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      chan_r     <= chan_nxt;
      mrun_r     <= mrun_nxt;
      pend_r     <= pend_nxt;
      enDly_r    <= chanEn;
      unitDone_r <= unitDone_nxt;
      unitChan_r <= unitChan_nxt;
      xferDone_r <= xferDone_nxt;
    end
  end

  // data path through the buffer; a full buffer holds off the read cycle
  assign fillIf.data   = rdData;
  assign fillIf.valid  = (state_r == dbcs_pkg::ST_READ) && cycAck;
  assign drainIf.ready = (state_r == dbcs_pkg::ST_WRITE) && cycAck;
  assign wrData        = drainIf.data;

  // cycle requests go to the bus controller, which applies the area's
  // width and wait settings exactly as for CPU cycles
  assign cycReq   = ((state_r == dbcs_pkg::ST_READ) && fillIf.ready) ||
                    ((state_r == dbcs_pkg::ST_WRITE) && drainIf.valid);
  assign cycWrite = (state_r == dbcs_pkg::ST_WRITE);
  assign cycChan  = chan_r;

  // bus held from grant through the dead cycle, dropped during release
  assign busReq = (state_r == dbcs_pkg::ST_IDLE) ? anyPend :
                  (state_r != dbcs_pkg::ST_RELEASE);

  // only off-chip targets put the address on the external pins
  assign extAddrEn = ((state_r == dbcs_pkg::ST_READ) && !srcInternal[chan_r]) ||
                     ((state_r == dbcs_pkg::ST_WRITE) && !dstInternal[chan_r]);

  // an on-chip-only pair may share time with the external master,
  // unless the write buffer still holds an outbound write
  assign internalOnly = srcInternal[chan_r] && dstInternal[chan_r] && !writeBufBusy;
  assign extReleaseOk = (state_r == dbcs_pkg::ST_IDLE) || (state_r == dbcs_pkg::ST_RELEASE) ||
                        (state_r == dbcs_pkg::ST_HOLD) ||
                        ((inPair || state_r == dbcs_pkg::ST_DEAD) && internalOnly);

  // status; transfer end goes only to the counter logic, no strobe pin exists
  assign masterRunFlag = mrun_r;
  assign reqPending    = pend_r;
  assign unitDone      = unitDone_r;
  assign unitChan      = unitChan_r;
  assign xferDone      = xferDone_r;

endmodule : dbcs_sequencer

// ### verification/dbcs_checker.sv
`timescale 1ns/10ps
// watches the sequencer ports only
module dbcs_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // controls
  input wire logic [3:0] channelRunFlag,
  input wire logic [1:0] masterRunSet,
  input wire logic [1:0] masterRunClr,
  input wire logic [1:0] fullAddrMode,
  input wire logic [3:0] xferMode,
  input wire logic [3:0] levelReqSel,
  input wire logic [3:0] transferRequestLine_n,
  input wire logic       nmi,
  input wire logic [3:0] lastUnit,
  input wire logic [3:0] srcInternal,
  input wire logic [3:0] dstInternal,
  input wire logic       extBusReq,
  // bus side
  input wire logic       busReq,
  input wire logic       cycReq,
  input wire logic       cycWrite,
  input wire logic [1:0] cycChan,
  input wire logic       extAddrEn,
  input wire logic       cycAck,
  input wire logic       extReleaseOk,
  // status
  input wire logic [1:0] masterRunFlag,
  input wire logic [3:0] reqPending,
  input wire logic       unitDone,
  input wire logic [1:0] unitChan,
  input wire logic       xferDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] md;
  logic       full;
  logic       wrEnd;
  logic       keep;
  // mode of the channel owning the cycle; keep means nothing asks the burst to stop
  assign md    = xferMode[2*cycChan[1] +: 2];
  assign full  = fullAddrMode[cycChan[1]];
  assign wrEnd = cycReq && cycWrite && cycAck;
  assign keep  = channelRunFlag[cycChan] && masterRunFlag[cycChan[1]] && !nmi && !extBusReq
                 && !masterRunClr[cycChan[1]] && !levelReqSel[cycChan] && !lastUnit[cycChan];
  // dead state, then the bus goes back
  sequence deadFree;
    xferDone && busReq && !cycReq ##1 !busReq;
  endsequence
  // the next read of the same channel follows at once
  sequence nextRead;
    cycReq && !cycWrite && $stable(cycChan);
  endsequence
  a_pair_write: assert property (cycReq && !cycWrite && cycAck |=> cycReq && cycWrite && $stable(cycChan))
    else $error("read not followed by its write");
  a_ext_held: assert property (cycReq && extAddrEn |-> !extReleaseOk)
    else $error("external release inside a dma cycle");
  a_int_quiet: assert property (cycReq && (cycWrite ? dstInternal[cycChan] : srcInternal[cycChan]) |-> !extAddrEn)
    else $error("internal target driven outside");
  a_unit_flag: assert property (wrEnd |=> unitDone && unitChan == $past(cycChan))
    else $error("unit end not flagged");
  a_dead_end: assert property (wrEnd && lastUnit[cycChan] |=> deadFree)
    else $error("no single dead state at transfer end");
  a_steal_free: assert property (wrEnd && !lastUnit[cycChan] && (!full || md == dbcs_pkg::MODE_STEAL) |=> !busReq)
    else $error("bus kept after a stolen unit");
  a_burst_keep: assert property (wrEnd && full && md == dbcs_pkg::MODE_BURST && keep |=> nextRead)
    else $error("burst broken");
  a_nmi_stop: assert property (nmi && fullAddrMode[0] && xferMode[1:0] == dbcs_pkg::MODE_BURST |=> !masterRunFlag[0])
    else $error("nmi left burst channel running");
  a_nmi_block: assert property (nmi && fullAddrMode[0] && xferMode[1:0] == dbcs_pkg::MODE_BLOCK && !masterRunSet[0]
    && !masterRunClr[0] |=> masterRunFlag[0] == $past(masterRunFlag[0])) else $error("nmi touched block channel");
  a_pend_cause: assert property ($rose(reqPending[1]) |-> $past(channelRunFlag[1])
    && (!$past(levelReqSel[1]) || !$past(transferRequestLine_n[1]))) else $error("pending without cause");
  a_off_drop: assert property (!channelRunFlag[1] |=> !reqPending[1])
    else $error("disabled channel still pending");
endmodule : dbcs_checker

// ### verification/dbcs_bus_model.sv
`timescale 1ns/10ps
// bus controller and cpu stand-in facing the sequencer
module dbcs_bus_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // from the sequencer
  input  wire logic        busReq,
  input  wire logic        cycReq,
  input  wire logic        cycWrite,
  input  wire logic [15:0] wrData,
  // wait states of the addressed area
  input  wire logic [1:0]  waitSt,
  // to the sequencer
  output logic             busGrant,
  output logic             cycAck,
  output logic [15:0]      rdData,
  output logic             cpuCycleDone,
  // last word written, for the bench
  output logic [15:0]      lastWr
);
  logic [1:0]  waitCnt;
  logic [15:0] rdCnt;
  // dma cycles get the same wait count as cpu cycles in the area
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {busGrant, cycAck, cpuCycleDone} <= 3'h0;
      {rdData, lastWr, rdCnt}          <= 48'h0;
      waitCnt                          <= 2'h0;
    end else begin
      busGrant     <= busReq; // grant comes one cycle late, as a slow arbiter would
      cpuCycleDone <= !busReq && !cpuCycleDone; // cpu fits a cycle into each free spell
      cycAck       <= 1'h0;
      rdData       <= ~rdData; // no stale word outside an ack
      if (cycAck && cycWrite)
        lastWr <= wrData;
      if (cycReq && !cycAck) begin
        waitCnt <= waitCnt + 2'h1;
        if (waitCnt == waitSt) begin
          waitCnt <= 2'h0;
          cycAck  <= 1'h1;
          if (!cycWrite) begin
            rdData <= rdCnt;
            rdCnt  <= rdCnt + 16'h1;
          end
        end
      end
    end
  end
endmodule : dbcs_bus_model

// ### verification/dma_bus_cycle_sequencer_bench.sv
`timescale 1ns/10ps
// self-checking bench for the bus-cycle sequencer
module dma_bus_cycle_sequencer_bench;
  logic        clk, rst_n, nmi, extBusReq, writeBufBusy, busGrant, cycAck, cpuCycleDone;
  logic        busReq, cycReq, cycWrite, extAddrEn, extReleaseOk, unitDone, xferDone;
  logic [1:0]  masterRunSet, masterRunClr, fullAddrMode, cycChan, masterRunFlag, unitChan, waitSt;
  logic [3:0]  channelRunFlag, xferMode, levelReqSel, transferRequestLine_n, lastUnit, blockEnd;
  logic [3:0]  srcInternal, dstInternal, reqPending;
  logic [15:0] rdData, wrData, lastWr, expWr;
  int          errors, samplesChecked;

  dbcs_sequencer dut (.clk, .rst_n, .channelRunFlag, .masterRunSet, .masterRunClr, .fullAddrMode, .xferMode,
    .levelReqSel, .transferRequestLine_n, .nmi, .lastUnit, .blockEnd, .srcInternal, .dstInternal, .busReq,
    .busGrant, .cycReq, .cycWrite, .cycChan, .extAddrEn, .cycAck, .rdData, .wrData, .cpuCycleDone, .extBusReq,
    .writeBufBusy, .extReleaseOk, .masterRunFlag, .reqPending, .unitDone, .unitChan, .xferDone);
  dbcs_bus_model busModel (.clk, .rst_n, .busReq, .cycReq, .cycWrite, .wrData, .waitSt, .busGrant, .cycAck,
    .rdData, .cpuCycleDone, .lastWr);

  // clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    if (errors == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // wait for one unit and judge its report and the word written
  task automatic one(input logic [1:0] ch, input logic last);
    int t;
    t = 0;
    while (unitDone !== 1'h1 && t < 500) begin
      @(negedge clk);
      t++;
    end
    chk("unitDone", unitDone, 1'h1);
    chk("unitChan", unitChan, ch);
    chk("xferDone", xferDone, last);
    chk("wrData", lastWr, expWr);
    expWr++;
    @(negedge clk);
  endtask : one

  // n units, the last one brings the counter to zero
  task automatic units(input logic [1:0] ch, input int n);
    for (int k = 1; k <= n; k++) begin
      lastUnit = (k == n) ? 4'h1 << ch : 4'h0;
      blockEnd = lastUnit;
      one(ch, k == n);
    end
    {lastUnit, blockEnd} = 8'h0;
    channelRunFlag[ch] = 1'h0;
  endtask : units

  task automatic waitIdle();
    int t;
    t = 0;
    while (busReq !== 1'h0 && t < 300) begin
      @(negedge clk);
      t++;
    end
    chk("busReq", busReq, 1'h0);
  endtask : waitIdle

  // full address channel: both run flags needed
  task automatic start(input logic [1:0] ch, input logic [1:0] md);
    fullAddrMode[ch[1]] = 1'h1;
    xferMode[2*ch[1] +: 2] = md;
    masterRunSet[ch[1]] = 1'h1;
    @(negedge clk);
    masterRunSet = 2'h0;
    chk("masterRunFlag", masterRunFlag[ch[1]], 1'h1);
    channelRunFlag[ch] = 1'h1;
  endtask : start

  task automatic tSteal();
    for (int w = 0; w < 3; w += 2) begin
      waitSt = 2'(w);
      start(2'h0, dbcs_pkg::MODE_STEAL);
      units(2'h0, 3);
      waitIdle();
    end
  endtask : tSteal

  // burst held off by an external master between units
  task automatic tBurst();
    int t;
    waitSt = 2'h1;
    start(2'h2, dbcs_pkg::MODE_BURST);
    one(2'h2, 1'h0);
    extBusReq = 1'h1;
    t = 0;
    while (extReleaseOk !== 1'h1 && t < 100) begin
      @(negedge clk);
      t++;
    end
    chk("cycReq", cycReq, 1'h0);
    chk("unitDone", unitDone, 1'h1);
    expWr++;
    @(negedge clk);
    extBusReq = 1'h0;
    units(2'h2, 3);
    waitIdle();
  endtask : tBurst

  // nmi lands while the final unit is under way, then software restarts
  task automatic tNmi();
    waitSt = 2'h0;
    start(2'h0, dbcs_pkg::MODE_BURST);
    one(2'h0, 1'h0);
    lastUnit = 4'h1;
    nmi = 1'h1;
    @(negedge clk);
    nmi = 1'h0;
    chk("masterRunFlag", masterRunFlag[0], 1'h0);
    one(2'h0, 1'h1);
    lastUnit = 4'h0;
    waitIdle();
    chk("reqPending", reqPending, 4'h0);
    masterRunSet[0] = 1'h1;
    @(negedge clk);
    masterRunSet = 2'h0;
    one(2'h0, 1'h0);
    // channel flag dropped while the next unit runs: that unit ends, then the bus goes
    channelRunFlag[0] = 1'h0;
    one(2'h0, 1'h0);
    chk("busReq", busReq, 1'h0);
    channelRunFlag[0] = 1'h1;
    units(2'h0, 1);
    waitIdle();
  endtask : tNmi

  // level-started block on internal memory, nmi ignored
  task automatic tBlock();
    {srcInternal, dstInternal} = 8'h11;
    levelReqSel[0] = 1'h1; // level request select is set by software
    transferRequestLine_n[0] = 1'h0;
    start(2'h0, dbcs_pkg::MODE_BLOCK);
    blockEnd = 4'h1;
    one(2'h0, 1'h0); // a one-unit block
    blockEnd = 4'h0;
    // the line is still low, yet the dead cycle must not re-arm the channel
    chk("reqPending", reqPending, 4'h0);
    one(2'h0, 1'h0); // next block; its following pair is on-chip only
    chk("extReleaseOk", extReleaseOk, 1'h1);
    {nmi, writeBufBusy} = 2'h3;
    @(negedge clk);
    chk("masterRunFlag", masterRunFlag[0], 1'h1);
    chk("extReleaseOk", extReleaseOk, 1'h0);
    {nmi, writeBufBusy} = 2'h0;
    units(2'h0, 2);
    {srcInternal, dstInternal, levelReqSel} = 12'h0;
    transferRequestLine_n = 4'hf;
    waitIdle();
  endtask : tBlock

  // three short-mode requests at once, served in fixed order
  task automatic tPrio();
    int t;
    fullAddrMode = 2'h0;
    levelReqSel = 4'hf; // all level driven, so the high line keeps 0A quiet
    transferRequestLine_n = 4'h1;
    channelRunFlag = 4'hf;
    for (int c = 1; c < 4; c++) begin
      t = 0;
      while (!(cycReq === 1'h1 && cycWrite === 1'h0) && t < 300) begin
        @(negedge clk);
        t++;
      end
      chk("cycChan", cycChan, 16'(c));
      transferRequestLine_n[c] = 1'h1;
      one(2'(c), 1'h0);
    end
    repeat (10) @(negedge clk);
    chk("reqPending", reqPending, 4'h0);
    chk("busReq", busReq, 1'h0);
    channelRunFlag = 4'h0;
  endtask : tPrio

  // main sequence, inputs change on the falling edge
  initial begin
    rst_n = 1'h0;
    {nmi, extBusReq, writeBufBusy, masterRunSet, masterRunClr, fullAddrMode, waitSt} = 11'h0;
    {channelRunFlag, xferMode, levelReqSel, lastUnit, blockEnd, srcInternal, dstInternal} = 28'h0;
    transferRequestLine_n = 4'hf;
    {expWr, errors, samplesChecked} = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    chk("reqPending", reqPending, dbcs_pkg::PEND_RST);
    chk("masterRunFlag", masterRunFlag, dbcs_pkg::MRUN_RST);
    chk("busReq", {busReq, cycReq, extReleaseOk}, 3'h1);
    tSteal();
    tBurst();
    tNmi();
    tBlock();
    tPrio();
    final_report();
  end

  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    errors++;
    final_report();
  end
endmodule : dma_bus_cycle_sequencer_bench

bind dbcs_sequencer dbcs_checker checkerInst (.clk, .rst_n, .channelRunFlag, .masterRunSet, .masterRunClr,
  .fullAddrMode, .xferMode, .levelReqSel, .transferRequestLine_n, .nmi, .lastUnit, .srcInternal, .dstInternal,
  .extBusReq, .busReq, .cycReq, .cycWrite, .cycChan, .extAddrEn, .cycAck, .extReleaseOk, .masterRunFlag,
  .reqPending, .unitDone, .unitChan, .xferDone);
